// ---- hw/spm_macrocell_array.sv ----
// Sum-of-products array with ten output macrocells and an AXI4-Lite fuse port
// Contract
// RQ1 - Each output ORs its own 8..16 terms
// RQ2 - Set term loads ones at clock edge
// RQ3 - Reset term clears registers to zero
// RQ4 - Set and reset terms shared by all
// RQ5 - Pin level follows programmed macrocell polarity
// RQ6 - Test preload loads any register state
// RQ7 - Tester drives pin while preload held
// RQ8 - Any output pin usable as input
// RQ9 - Power-up clears every output register
// RQ10 - After power-up active-low pins read high
// RQ11 - Security fuse makes fuses read open
// RQ12 - Two fuses select mode and polarity
// RQ13 - Combinational mode bypasses register, pin feedback
// RQ14 - Registered mode drives register, register feedback
// RQ15 - Own enable term per output driver
// RQ16 - Reset beats set at the same edge
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
module spm_macrocell_array (
	// Clock and reset
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	// Dedicated logic inputs
	input  wire logic [spm_pkg::NUM_IN-1:0]  din,
	// Macrocell I/O pins
	input  wire logic [spm_pkg::NUM_MC-1:0]  io_in,
	output logic      [spm_pkg::NUM_MC-1:0]  io_out,
	output logic      [spm_pkg::NUM_MC-1:0]  io_oe,
	// Test preload control pin
	input  wire logic                        preload_hv,
	// AXI4-Lite write address
	input  wire logic [spm_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	// AXI4-Lite write response
	output logic      [1:0]                  s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [spm_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	// AXI4-Lite read data
	output logic      [31:0]                 s_axi_rdata,
	output logic      [1:0]                  s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready
);

	localparam int NMC = spm_pkg::NUM_MC;
	localparam int NIN = spm_pkg::NUM_IN;
	localparam int NL  = spm_pkg::NUM_LIT;
	localparam int NT  = spm_pkg::NUM_TERMS;
	// Term fuse row hit for an address
	function automatic logic term_hit(input logic [11:0] a);
		return (a[11:3] >= spm_pkg::TERM_BASE_IDX) &&
			(a[11:3] < spm_pkg::TERM_BASE_IDX + 9'(NT));
	endfunction : term_hit
	// Term fuse row index for an address
	function automatic logic [7:0] term_sel(input logic [11:0] a);
		logic [8:0] d;
		d = a[11:3] - spm_pkg::TERM_BASE_IDX;
		return d[7:0];
	endfunction : term_sel
	// Byte-lane merge of a bus write into an old word
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		for (int b = 0; b < 4; b++) begin
			r[8*b +: 8] = s[b] ? d[8*b +: 8] : old[8*b +: 8];
		end
		return r;
	endfunction : wmerge
	// Fuse storage and configuration
	logic [NL-1:0]  fuse_reg [NT];        // Term fuse rows
	logic [NMC-1:0] mode_reg;             // mode_feedback_select_fuse per macrocell
	logic [NMC-1:0] pol_reg;              // output_polarity_select_fuse per macrocell
	logic           sec_reg;              // Security fuse, one-way
	// Synchronisers for everything arriving from pins
	logic [NIN-1:0] din_meta, din_s;
	logic [NMC-1:0] io_meta, io_s;
	logic           pl_meta, pl_s;
	// Array state
	logic [NMC-1:0] q_reg;                // Output registers
	logic [NMC-1:0] q_next;
	logic [NMC-1:0] fb;                   // Feedback into the array
	logic [NMC-1:0] sum;                  // OR of each macrocell's terms
	logic [NMC-1:0] oe_t;                 // Enable terms
	logic [NMC-1:0] pl_d;                 // Register value implied by pin at preload
	logic [NL-1:0]  lits;
	logic [NT-1:0]  term_v;
	logic           set_t, rst_t;
	logic [NMC-1:0] io_out_reg, io_oe_reg;
	// Bus state
	logic        awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
	logic        aw_full, w_full;
	logic [11:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic [1:0]  bresp_reg, rresp_reg;
	logic [31:0] rdata_reg;
	logic        do_write, wr_map;
	logic [7:0]  w_idx;
	logic [31:0] lo_merged, hi_merged;
	logic [31:0] rd_word;
	logic        rd_map;
	// Two flops on every pin input before the array looks at it
	always_ff @(posedge aclk) begin
		din_meta <= din;
		din_s    <= din_meta;
		io_meta  <= io_in;
		io_s     <= io_meta;
		pl_meta  <= preload_hv;
		pl_s     <= pl_meta;
	end
	// Array columns: inputs plus macrocell feedback, true and complement
	assign lits = {~fb, ~din_s, fb, din_s};
	// Every term row evaluated by its own AND gate
	generate
		for (genvar t = 0; t < NT; t++) begin : g_term
			spm_product_term u_term (
				.lits (lits),
				.fuse (fuse_reg[t]),
				.term (term_v[t])
			);
		end
	endgenerate
	// Global terms drive all registers at once, never per macrocell
	assign set_t = term_v[spm_pkg::SET_TERM];  // RQ4
	assign rst_t = term_v[spm_pkg::RST_TERM];  // RQ4
	// Per-macrocell sum, enable, feedback and preload value
	generate
		for (genvar m = 0; m < NMC; m++) begin : g_mc
			localparam int B = spm_pkg::term_base(m);
			localparam int C = spm_pkg::TERM_COUNT[m];
			// Uneven term share; the long sums sit in the middle cells
			assign sum[m]  = |term_v[B +: C];                 // RQ1
			assign oe_t[m] = term_v[spm_pkg::OE_BASE + m];    // RQ15
			// In combinational mode a disabled pin still feeds the array, so it serves as an input
			assign fb[m]   = mode_reg[m] ? io_s[m] : q_reg[m]; // RQ13 RQ14 RQ8 RQ12
			// Pin level maps back through polarity into register sense
			assign pl_d[m] = pol_reg[m] ? io_s[m] : ~io_s[m]; // RQ6
		end
	endgenerate
	// Next register value; reset first, then preload, then set, then sum
	always_comb begin
		if (rst_t) begin
			q_next = '0;                  // RQ3 RQ16
		end else if (pl_s) begin
			q_next = pl_d;                // RQ6
		end else if (set_t) begin
			q_next = '1;                  // RQ2
		end else begin
			q_next = sum;                 // RQ14
		end
	end
	// Output registers; the reset term acts at the first edge that sees it,
	// the nearest a single-clock model gets to an unclocked clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q_reg <= '0;                  // RQ9
		end else begin
			q_reg <= q_next;              // RQ2 RQ3
		end
	end
	// Pin drivers: value through polarity, enable from its own term
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			io_out_reg <= spm_pkg::PIN_RST; // RQ10
			io_oe_reg  <= '0;
		end else begin
			for (int m = 0; m < NMC; m++) begin
				// Combinational cells bypass the register, registered ones show it
				io_out_reg[m] <= pol_reg[m] ~^ (mode_reg[m] ? sum[m] : q_next[m]); // RQ5 RQ13
			end
			// Drivers stay off while the tester forces the pins for preload
			io_oe_reg <= oe_t & {NMC{~pl_s}}; // RQ15 RQ7
		end
	end
	// Write path: address and data are taken in either order
	assign do_write = aw_full && w_full && !bvalid_reg;
	assign w_idx    = term_sel(aw_addr_reg);
	assign wr_map   = term_hit(aw_addr_reg) || aw_addr_reg == spm_pkg::MODE_OFS ||
		aw_addr_reg == spm_pkg::POL_OFS || aw_addr_reg == spm_pkg::SEC_OFS;
	assign lo_merged = wmerge(fuse_reg[w_idx][31:0], w_data_reg, w_strb_reg);
	assign hi_merged = wmerge({{(32 - spm_pkg::LIT_HI_W){1'b0}}, fuse_reg[w_idx][NL-1:32]},
		w_data_reg, w_strb_reg);
	// Write address channel; ready falls once taken, returns after the response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'b1;
			aw_full     <= 1'b0;
			aw_addr_reg <= '0;
		end else if (s_axi_awvalid && awready_reg) begin
			awready_reg <= 1'b0;
			aw_full     <= 1'b1;
			aw_addr_reg <= s_axi_awaddr;
		end else if (do_write) begin
			aw_full <= 1'b0;
		end else if (bvalid_reg && s_axi_bready) begin
			awready_reg <= 1'b1;
		end
	end
	// Write data channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready_reg <= 1'b1;
			w_full     <= 1'b0;
			w_data_reg <= '0;
			w_strb_reg <= '0;
		end else if (s_axi_wvalid && wready_reg) begin
			wready_reg <= 1'b0;
			w_full     <= 1'b1;
			w_data_reg <= s_axi_wdata;
			w_strb_reg <= s_axi_wstrb;
		end else if (do_write) begin
			w_full <= 1'b0;
		end else if (bvalid_reg && s_axi_bready) begin
			wready_reg <= 1'b1;
		end
	end
	// Write response; unmapped addresses answer with an error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= spm_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= wr_map ? spm_pkg::RESP_OKAY : spm_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// Macrocell select fuses and the one-way security fuse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_reg <= spm_pkg::MODE_RST;
			pol_reg  <= spm_pkg::POL_RST;
			sec_reg  <= 1'b0;
		end else if (do_write) begin
			if (aw_addr_reg == spm_pkg::MODE_OFS) begin
				mode_reg <= NMC'(wmerge({22'h000000, mode_reg}, w_data_reg, w_strb_reg));
			end
			if (aw_addr_reg == spm_pkg::POL_OFS) begin
				pol_reg <= NMC'(wmerge({22'h000000, pol_reg}, w_data_reg, w_strb_reg));
			end
			// A blown fuse cannot be restored; only reset clears it
			if (aw_addr_reg == spm_pkg::SEC_OFS && w_strb_reg[0] && w_data_reg[0]) begin
				sec_reg <= 1'b1;
			end
		end
	end
	// Term fuse rows; low word then upper bits in the following word
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int t = 0; t < NT; t++) begin
				fuse_reg[t] <= spm_pkg::FUSE_RST;
			end
		end else if (do_write && term_hit(aw_addr_reg)) begin
			if (!aw_addr_reg[2]) begin
				fuse_reg[w_idx][31:0] <= lo_merged;
			end else begin
				fuse_reg[w_idx][NL-1:32] <= hi_merged[spm_pkg::LIT_HI_W-1:0];
			end
		end
	end

	// Read decode; fuses read as blown once security is set
	always_comb begin
		rd_word = '0;
		rd_map  = 1'b1;
		if (term_hit(s_axi_araddr)) begin
			if (!s_axi_araddr[2]) begin
				rd_word = fuse_reg[term_sel(s_axi_araddr)][31:0];
			end else begin
				rd_word[spm_pkg::LIT_HI_W-1:0] = fuse_reg[term_sel(s_axi_araddr)][NL-1:32];
			end
			if (sec_reg) begin
				rd_word = s_axi_araddr[2] ? 32'h00000FFF : 32'hFFFFFFFF; // RQ11
			end
		end else begin
			case (s_axi_araddr)
				spm_pkg::MODE_OFS: rd_word[NMC-1:0] = sec_reg ? '1 : mode_reg; // RQ11
				spm_pkg::POL_OFS:  rd_word[NMC-1:0] = sec_reg ? '1 : pol_reg;  // RQ11
				spm_pkg::SEC_OFS:  rd_word[0] = sec_reg;
				spm_pkg::STAT_OFS: begin
					rd_word[NMC-1:0]              = q_reg;
					rd_word[spm_pkg::STAT_PL_BIT]  = pl_s;
					rd_word[spm_pkg::STAT_SET_BIT] = set_t;
					rd_word[spm_pkg::STAT_RST_BIT] = rst_t;
				end
				spm_pkg::PIN_OFS: begin
					rd_word[NMC-1:0]                      = io_s;
					rd_word[spm_pkg::PIN_OE_LSB +: NMC]   = io_oe_reg;
				end
				default: rd_map = 1'b0;
			endcase
		end
	end

	// Read channel; one read in flight, data taken at the address edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= '0;
			rresp_reg   <= spm_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && arready_reg) begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b1;
			rdata_reg   <= rd_word;
			rresp_reg   <= rd_map ? spm_pkg::RESP_OKAY : spm_pkg::RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg  <= 1'b0;
			arready_reg <= 1'b1;
		end
	end

	// Outputs straight from flops
	assign io_out        = io_out_reg;
	assign io_oe         = io_oe_reg;
	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

endmodule : spm_macrocell_array

// ---- hw/spm_pkg.sv ----
// Shared constants for the sum-of-products macrocell array
package spm_pkg;

	// Array geometry
	localparam int NUM_MC      = 10;                  // Output macrocells
	localparam int NUM_IN      = 12;                  // Dedicated inputs
	localparam int NUM_LIT     = 2 * (NUM_IN + NUM_MC); // True and complement columns
	localparam int LIT_HI_W    = NUM_LIT - 32;        // Fuse bits kept in the upper word
	localparam int TERM_COUNT [NUM_MC] = '{8, 10, 12, 14, 16, 16, 14, 12, 10, 8};
	localparam int SUM_TERMS   = 120;                 // Sum of TERM_COUNT, average 12
	localparam int OE_BASE     = SUM_TERMS;           // One enable term per macrocell
	localparam int SET_TERM    = OE_BASE + NUM_MC;    // Global synchronous set
	localparam int RST_TERM    = SET_TERM + 1;        // Global reset, taken at the next clock edge
	localparam int NUM_TERMS   = RST_TERM + 1;

	// Register map, byte addresses
	localparam int          ADDR_W    = 12;
	localparam logic [11:0] MODE_OFS  = 12'h000;     // Mode/feedback select fuses
	localparam logic [11:0] POL_OFS   = 12'h004;     // Polarity select fuses
	localparam logic [11:0] SEC_OFS   = 12'h008;     // Security fuse
	localparam logic [11:0] STAT_OFS  = 12'h00C;     // Register state and global terms
	localparam logic [11:0] PIN_OFS   = 12'h010;     // Pin levels and enables
	localparam logic [11:0] TERM_OFS  = 12'h400;     // Term fuses, 8 bytes per term
	localparam logic [8:0]  TERM_BASE_IDX = 9'h080;  // TERM_OFS in 8-byte units
	localparam int          STAT_PL_BIT  = 16;
	localparam int          STAT_SET_BIT = 17;
	localparam int          STAT_RST_BIT = 18;
	localparam int          PIN_OE_LSB   = 16;

	// Reset values
	localparam logic [NUM_MC-1:0]  MODE_RST = 10'h000;
	localparam logic [NUM_MC-1:0]  POL_RST  = 10'h000;
	localparam logic [NUM_MC-1:0]  PIN_RST  = 10'h3FF; // Active low with a cleared register
	localparam logic [NUM_LIT-1:0] FUSE_RST = 44'h000_0000_0000;

	// Bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// First term index of a macrocell's sum
	function automatic int term_base(input int m);
		int s;
		s = 0;
		for (int i = 0; i < m; i++) begin
			s += TERM_COUNT[i];
		end
		return s;
	endfunction : term_base

endpackage : spm_pkg

// ---- hw/spm_product_term.sv ----
// One programmable AND term of the logic array
`timescale 1ns/10ps
module spm_product_term (
	// Array columns
	input  wire logic [spm_pkg::NUM_LIT-1:0] lits,
	// Fuse row: 1 means blown, the column is disconnected
	input  wire logic [spm_pkg::NUM_LIT-1:0] fuse,
	// Term value
	output logic                             term
);

	// An intact fuse ties its column into the AND; an all-intact row is
	// always false because it sees a signal and its complement
	assign term = &(lits | fuse);

endmodule : spm_product_term

// ---- tb/programmable_sum_of_products_macrocells_tb.sv ----
// Self-checking bench for the macrocell array
`timescale 1ns/10ps
module programmable_sum_of_products_macrocells_tb;
	logic                       aclk = 1'b0;             // Bench clock
	logic                       aresetn = 1'b0;          // Reset, active low
	logic                       preload_hv = 1'b0;       // Preload control pin
	logic [spm_pkg::NUM_IN-1:0] din = '0;                // Dedicated inputs
	logic [spm_pkg::NUM_MC-1:0] io_in, io_out, io_oe;    // Pins
	logic [spm_pkg::NUM_MC-1:0] ext_val = '0, ext_en = '0; // Tester drive
	logic [spm_pkg::NUM_MC-1:0] mask, lv;                // Random enables and levels
	logic [11:0]                s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0]                s_axi_wdata = '0, s_axi_rdata;
	logic [3:0]                 s_axi_wstrb = 4'hF;      // Byte lanes of a write
	logic [1:0]                 s_axi_bresp, s_axi_rresp;
	logic                       s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic                       s_axi_arvalid = 0, s_axi_rready = 0;
	logic                       s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic                       s_axi_arready, s_axi_rvalid;
	int                         bad_count = 0, samples_checked = 0, k;
	int                         seed = 32'hf18d2170;     // Fixed seed
	localparam logic [43:0]     ONES = 44'hFFF_FFFF_FFFF; // Every column blown

	always #4 aclk = ~aclk;

	spm_macrocell_array dut_u (.aclk, .aresetn, .din, .io_in, .io_out, .io_oe, .preload_hv,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	spm_board board_u (.aclk, .io_out, .io_oe, .ext_val, .ext_en, .io_in);

	// Count and report one comparison
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : cmp

	// Verdict and end of run
	task automatic conclude;
		if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : conclude

	task automatic settle(input int n);
		repeat (n) @(posedge aclk);
	endtask : settle

	// Write one word; the response ready comes after a random stall
	task automatic axw(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] er = spm_pkg::RESP_OKAY);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if ($random(seed) & 1) s_axi_bready <= 1'b1;
		end while (!(s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1));
		s_axi_bready <= 1'b0;
		cmp("bresp", 32'(er), 32'(s_axi_bresp));
	endtask : axw

	// Read one word and compare data and response
	task automatic chk_rd(input logic [11:0] a, input logic [31:0] e,
		input logic [1:0] er = spm_pkg::RESP_OKAY);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if ($random(seed) & 1) s_axi_rready <= 1'b1;
		end while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1));
		s_axi_rready <= 1'b0;
		cmp("rdata", e, s_axi_rdata);
		cmp("rresp", 32'(er), 32'(s_axi_rresp));
	endtask : chk_rd

	// A fuse row travels as two words, low bits first
	task automatic row(input int t, input logic [43:0] v);
		axw(spm_pkg::TERM_OFS + 12'(8 * t), v[31:0]);
		axw(spm_pkg::TERM_OFS + 12'(8 * t + 4), {20'h0, v[43:32]});
	endtask : row

	// Hang guard, far beyond the expected run
	initial begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		conclude();
	end

	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		settle(2);
		cmp("io_out", 32'h3FF, 32'(io_out));
		cmp("io_oe", 32'h0, 32'(io_oe));
		chk_rd(spm_pkg::MODE_OFS, 32'h0);
		chk_rd(spm_pkg::POL_OFS, 32'h0);
		chk_rd(spm_pkg::STAT_OFS, 32'h0);
		chk_rd(12'h020, 32'h0, spm_pkg::RESP_SLVERR);
		axw(spm_pkg::STAT_OFS, 32'h1, spm_pkg::RESP_SLVERR);
		// Set term always true loads ones into all ten registers
		row(spm_pkg::SET_TERM, ONES);
		settle(4);
		chk_rd(spm_pkg::STAT_OFS, 32'h0002_03FF);
		cmp("io_out", 32'h0, 32'(io_out));
		axw(spm_pkg::POL_OFS, 32'h3FF);
		settle(4);
		cmp("io_out", 32'h3FF, 32'(io_out));
		// Reset term wins over the pending set
		row(spm_pkg::RST_TERM, ONES);
		settle(4);
		chk_rd(spm_pkg::STAT_OFS, 32'h0006_0000);
		cmp("io_out", 32'h0, 32'(io_out));
		row(spm_pkg::SET_TERM, '0);
		row(spm_pkg::RST_TERM, '0);
		// Each driver follows its own enable term
		mask = 10'($random(seed));
		for (int m = 0; m < spm_pkg::NUM_MC; m++) begin
			row(spm_pkg::OE_BASE + m, mask[m] ? ONES : 44'h0);
		end
		settle(4);
		cmp("io_oe", 32'(mask), 32'(io_oe));
		// Tester preloads a random state through the pins
		lv = 10'($random(seed));
		ext_val <= lv;
		ext_en <= '1;
		preload_hv <= 1'b1;
		settle(6);
		chk_rd(spm_pkg::STAT_OFS, {15'h0, 1'b1, 6'h0, lv});
		chk_rd(spm_pkg::PIN_OFS, {22'h0, lv});
		cmp("io_oe", 32'h0, 32'(io_oe));
		ext_en <= '0;
		@(posedge aclk);
		preload_hv <= 1'b0;
		// Cell 4 combinational, its last term follows one input
		axw(spm_pkg::MODE_OFS, 32'h010);
		k = {$random(seed)} % 12;
		row(59, ONES ^ (44'h1 << k));
		chk_rd(spm_pkg::TERM_OFS + 12'(8 * 59), ~(32'h1 << k));
		for (int j = 0; j < 6; j++) begin
			din <= 12'($random(seed));
			settle(4);
			cmp("io_out4", 32'(din[k]), 32'(io_out[4]));
		end
		// Only byte lane 1 lands: cells 8 and 9 turn combinational
		s_axi_wstrb <= 4'h2;
		axw(spm_pkg::MODE_OFS, 32'hFFFF_FFFF);
		s_axi_wstrb <= 4'hF;
		chk_rd(spm_pkg::MODE_OFS, 32'h310);
		// Security hides every fuse as blown
		axw(spm_pkg::SEC_OFS, 32'h1);
		chk_rd(spm_pkg::TERM_OFS + 12'(8 * 59), 32'hFFFF_FFFF);
		chk_rd(spm_pkg::TERM_OFS + 12'(8 * 59 + 4), 32'h0000_0FFF);
		chk_rd(spm_pkg::MODE_OFS, 32'h3FF);
		// Second reset in mid-run
		aresetn <= 1'b0;
		settle(3);
		aresetn <= 1'b1;
		settle(2);
		cmp("io_out", 32'h3FF, 32'(io_out));
		chk_rd(spm_pkg::MODE_OFS, 32'h0);
		conclude();
	end
endmodule : programmable_sum_of_products_macrocells_tb

// ---- tb/spm_board.sv ----
// Board model that resolves the macrocell pin levels
`timescale 1ns/10ps
module spm_board (
	// Clock
	input  wire logic                        aclk,
	// Design pin side
	input  wire logic [spm_pkg::NUM_MC-1:0]  io_out,
	input  wire logic [spm_pkg::NUM_MC-1:0]  io_oe,
	// Tester drive while a pin serves as input
	input  wire logic [spm_pkg::NUM_MC-1:0]  ext_val,
	input  wire logic [spm_pkg::NUM_MC-1:0]  ext_en,
	// Resolved level
	output logic      [spm_pkg::NUM_MC-1:0]  io_in
);
	logic [spm_pkg::NUM_MC-1:0] held = '0; // Last level of each pin

	// Design driver wins, then the tester; a floating pin flips every cycle
	always_comb begin
		for (int i = 0; i < spm_pkg::NUM_MC; i++) begin
			io_in[i] = io_oe[i] ? io_out[i] : (ext_en[i] ? ext_val[i] : ~held[i]);
		end
	end

	// Remember the level so a float never repeats it
	always @(posedge aclk) begin
		held <= io_in;
	end
endmodule : spm_board

// ---- tb/spm_props.sv ----
// Port checker for the macrocell array
`timescale 1ns/10ps
module spm_props (
	// Clock and reset
	input wire logic                       aclk,
	input wire logic                       aresetn,
	// Pins
	input wire logic                       preload_hv,
	input wire logic [spm_pkg::NUM_MC-1:0] io_out,
	input wire logic [spm_pkg::NUM_MC-1:0] io_oe,
	// Bus handshakes
	input wire logic                       s_axi_awvalid,
	input wire logic                       s_axi_awready,
	input wire logic                       s_axi_wready,
	input wire logic                       s_axi_bvalid,
	input wire logic                       s_axi_bready,
	input wire logic [1:0]                 s_axi_bresp,
	input wire logic                       s_axi_arvalid,
	input wire logic                       s_axi_arready,
	input wire logic                       s_axi_rvalid,
	input wire logic                       s_axi_rready,
	input wire logic [31:0]                s_axi_rdata,
	input wire logic [1:0]                 s_axi_rresp
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_pwr; $rose(aresetn) |-> io_out == spm_pkg::PIN_RST && io_oe == '0; endproperty
	a_pwr: assert property (p_pwr) else $error("pins wrong after reset");
	property p_pre; preload_hv [*4] |-> io_oe == '0; endproperty
	a_pre: assert property (p_pre) else $error("driver on during preload");
	property p_aw; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
	a_aw: assert property (p_aw) else $error("awready kept high");
	property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_bh: assert property (p_bh) else $error("write answer dropped");
	property p_bd;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
	endproperty
	a_bd: assert property (p_bd) else $error("write channel not reopened");
	property p_rn; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rn: assert property (p_rn) else $error("read answer late");
	property p_rh;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
	endproperty
	a_rh: assert property (p_rh) else $error("read answer dropped");
	property p_ab; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_ab: assert property (p_ab) else $error("read taken while busy");
endmodule : spm_props

bind spm_macrocell_array spm_props chk_u (.aclk, .aresetn, .preload_hv, .io_out, .io_oe,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
